// File: src/ndm_pkg.sv
// Package: address map, field positions, reset values and sizes of the nibble data memory
package ndm_pkg;
  localparam int          ADDR_W         = 10;
  localparam int          DATA_W         = 4;
  localparam int          RAM_WORDS      = 832;
  localparam int          DISP_WORDS     = 48;
  localparam int          IO_WORDS       = 33;
  localparam int          SPACE_WORDS    = 865;
  localparam int          STACK_PUSH     = 3;
  localparam logic [9:0]  RAM_LAST       = 10'h33F;
  localparam logic [9:0]  RWIN_FIRST     = 10'h000;
  localparam logic [9:0]  RWIN_LAST      = 10'h00F;
  localparam logic [9:0]  DISP0_FIRST    = 10'h040;
  localparam logic [9:0]  DISP0_LAST     = 10'h06F;
  localparam logic [9:0]  DISP2_FIRST    = 10'h240;
  localparam logic [9:0]  DISP2_LAST     = 10'h26F;
  localparam logic [9:0]  LCD_BLANK_ADDR = 10'h2D0;
  localparam logic [9:0]  CLK_TMR_ADDR   = 10'h2E0;
  localparam logic [9:0]  SW_HUND_ADDR   = 10'h2E1;
  localparam logic [9:0]  SW_TENTH_ADDR  = 10'h2E2;
  localparam logic [9:0]  IN_LEVEL_ADDR  = 10'h2E3;
  localparam logic [9:0]  IN_CMP_ADDR    = 10'h2E4;
  localparam logic [9:0]  IN_IRQ_ADDR    = 10'h2E5;
  localparam logic [9:0]  IO_AREA_FIRST  = 10'h2D0;
  localparam logic [9:0]  IO_AREA_LAST   = 10'h2FF;
  localparam int          LCD_BLANK_BIT  = 0;
  localparam int          TMR16_BIT      = 0;
  localparam int          TMR8_BIT       = 1;
  localparam logic [3:0]  LCD_BLANK_RST  = 4'h1;
  localparam logic [3:0]  ZERO_NIB       = 4'h0;
  localparam logic [7:0]  START_STEP     = 8'h00;
  localparam logic [3:0]  START_PAGE     = 4'h1;
  localparam logic [7:0]  VEC_FIRST      = 8'h01;
  localparam logic [7:0]  VEC_LAST       = 8'h0F;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'b000,
    SEL_RAM   = 3'b001,
    SEL_DISP  = 3'b010,
    SEL_IO    = 3'b011
  } ndm_sel_t;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ndm_req_t;

  typedef struct packed {
    logic [3:0] clkTmr;
    logic [3:0] swHund;
    logic [3:0] swTenth;
  } ndm_status_t;
endpackage

// File: src/ndm_data_map.sv
// Nibble data memory: RAM, display memory and first I/O registers behind one CPU bus
`timescale 1ns/1ps
// Summary of operation
// - RAM holds 832 four-bit words; the CPU reads and writes all but the 48 at 2D0H-2FFH, and with page 2 also 240H-26FH.
// - Each call or interrupt pushes three words into RAM and software keeps data off the stack.
// - Words 000H to 00FH form the window the register pointer addresses.
// - The space totals 865 words with 48 display words and 33 I/O words, all reached as memory.
// - With the page 0 option the display memory at 040H-06FH lies in RAM and reads and writes.
// - With the page 2 option the display memory at 240H-26FH takes writes only.
// - Unmapped addresses hold nothing and read an unspecified value, here zero.
// - 2E0H reads the clock timer bits, bit 0 the 16 Hz stage and bit 1 the 8 Hz stage.
// - 2E1H reads the stopwatch hundredths BCD digit, reset zero.
// - 2E2H reads the stopwatch tenths BCD digit, reset zero.
// - 2E3H reads the live levels of the four input lines with no reset value.
// - 2E4H is the read/write input comparison register, reset zero.
// - 2E5H is the read/write input interrupt enable, 1 enables, reset zero.
// - After reset execution starts at page 1 step 00H, vectors at steps 01H-0FH.
module ndm_data_map
#(
  parameter bit DISP_PAGE2 = 1'b0
)
(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire ndm_pkg::ndm_req_t   cpuReq,
  input  wire ndm_pkg::ndm_status_t periphStatus,
  input  wire logic [3:0]          inLines,
  output logic [3:0]               rdData,
  output logic                     rdValid,
  output logic                     regWindowHit,
  output logic                     lcdBlankN,
  output logic [3:0]               inCmp,
  output logic [3:0]               inIrqEn,
  output logic                     dispWrStrobe,
  output logic [5:0]               dispWrIndex,
  output logic [3:0]               dispWrData,
  output logic [7:0]               progStepCounter,
  output logic [3:0]               progPageCounter
);
  import ndm_pkg::*;

  // ==========================================================
  // Reset release
  // Async assert; release two edges later so all flops leave reset together
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ==========================================================
  // Address decode
  function automatic ndm_sel_t decodeSel(input logic [9:0] a);
    ndm_sel_t s;
    s = SEL_NONE;
    // I/O page wins over RAM: the RAM words behind it are never accessed
    if (DISP_PAGE2 && a >= DISP2_FIRST && a <= DISP2_LAST)
      s = SEL_DISP;
    else if (a == LCD_BLANK_ADDR || (a >= CLK_TMR_ADDR && a <= IN_IRQ_ADDR))
      s = SEL_IO;
    else if (a >= IO_AREA_FIRST && a <= IO_AREA_LAST)
      s = SEL_NONE;
    else if (a <= RAM_LAST)
      s = SEL_RAM;
    return s;
  endfunction

  function automatic logic isDisp0(input logic [9:0] a);
    return !DISP_PAGE2 && a >= DISP0_FIRST && a <= DISP0_LAST;
  endfunction

  ndm_sel_t sel;
  logic     wrRam;
  logic     wrIo;
  logic     ramAddrOk;

  always_comb
  begin
    sel       = decodeSel(cpuReq.addr);
    ramAddrOk = (sel == SEL_RAM);
    wrRam     = cpuReq.wr && ramAddrOk;
    wrIo      = cpuReq.wr && (sel == SEL_IO);
  end

  // ==========================================================
  // Data RAM, stack and page 0 display words live here too
  // Contents are not reset; the words under the I/O page stay unused
  logic [3:0] ramMem [RAM_WORDS];
  logic [3:0] ramRd;

  always_ff @(posedge clock)
  begin
    if (wrRam)
      ramMem[cpuReq.addr] <= cpuReq.wdata;
  end

  always_comb
  begin
    ramRd = ramAddrOk ? ramMem[cpuReq.addr] : ZERO_NIB;
  end

  // ==========================================================
  // I/O registers
  logic       lcdBlank_reg;
  logic [3:0] inCmp_reg;
  logic [3:0] inIrqEn_reg;

  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      lcdBlank_reg <= LCD_BLANK_RST[LCD_BLANK_BIT];
    else if (wrIo && cpuReq.addr == LCD_BLANK_ADDR)
      lcdBlank_reg <= cpuReq.wdata[LCD_BLANK_BIT];
  end

  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      inCmp_reg <= ZERO_NIB;
    else if (wrIo && cpuReq.addr == IN_CMP_ADDR)
      inCmp_reg <= cpuReq.wdata;
  end

  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
      inIrqEn_reg <= ZERO_NIB;
    else if (wrIo && cpuReq.addr == IN_IRQ_ADDR)
      inIrqEn_reg <= cpuReq.wdata;
  end

  // ==========================================================
  // Read mux
  logic [3:0] ioRd;
  // Unlisted I/O words fall through to zero

  always_comb
  begin
    ioRd = ZERO_NIB;
    unique case (cpuReq.addr)
      LCD_BLANK_ADDR: ioRd = {3'b000, lcdBlank_reg};
      CLK_TMR_ADDR:   ioRd = {2'b00, periphStatus.clkTmr[TMR8_BIT], periphStatus.clkTmr[TMR16_BIT]};
      SW_HUND_ADDR:   ioRd = periphStatus.swHund;
      SW_TENTH_ADDR:  ioRd = periphStatus.swTenth;
      IN_LEVEL_ADDR:  ioRd = inLines;
      IN_CMP_ADDR:    ioRd = inCmp_reg;
      IN_IRQ_ADDR:    ioRd = inIrqEn_reg;
      default:        ioRd = ZERO_NIB;
    endcase
  end

  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      rdData  <= ZERO_NIB;
      rdValid <= 1'b0;
    end
    else
    begin
      rdValid <= cpuReq.rd;
      if (cpuReq.rd)
        rdData <= (sel == SEL_RAM) ? ramRd : (sel == SEL_IO) ? ioRd : ZERO_NIB;
    end
  end

  // ==========================================================
  // Display write port and register window flag
  // Index and data follow the bus each cycle and mean something only with the strobe
  // display words go out to the LCD driver
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      dispWrStrobe <= 1'b0;
      dispWrIndex  <= 6'h00;
      dispWrData   <= ZERO_NIB;
      regWindowHit <= 1'b0;
    end
    else
    begin
      dispWrStrobe <= cpuReq.wr && (sel == SEL_DISP || isDisp0(cpuReq.addr));
      dispWrIndex  <= 6'(cpuReq.addr - (DISP_PAGE2 ? DISP2_FIRST : DISP0_FIRST));
      dispWrData   <= cpuReq.wdata;
      regWindowHit <= (cpuReq.rd || cpuReq.wr) && cpuReq.addr <= RWIN_LAST;
    end
  end

  // ==========================================================
  // Start address after reset
  // Held in flops so the outputs come straight from registers
  // reset start at page 1 step 00H
  always_ff @(posedge clock or negedge rstSync)
  begin
    if (!rstSync)
    begin
      progStepCounter <= START_STEP;
      progPageCounter <= START_PAGE;
    end
    else
    begin
      progStepCounter <= START_STEP;
      progPageCounter <= START_PAGE;
    end
  end

  always_comb
  begin
    lcdBlankN = lcdBlank_reg;
    inCmp     = inCmp_reg;
    inIrqEn   = inIrqEn_reg;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstSync);

  chk_lcd_write_takes: assert property (
    wrIo && cpuReq.addr == LCD_BLANK_ADDR |=> lcdBlankN == $past(cpuReq.wdata[0]))
    else $error("LCD control not updated");
  chk_cmp_write_takes: assert property (
    wrIo && cpuReq.addr == IN_CMP_ADDR |=> inCmp == $past(cpuReq.wdata))
    else $error("Comparison register not updated");
  chk_irq_write_takes: assert property (
    wrIo && cpuReq.addr == IN_IRQ_ADDR |=> inIrqEn == $past(cpuReq.wdata))
    else $error("Interrupt enable not updated");
  chk_level_read_live: assert property (
    cpuReq.rd && cpuReq.addr == IN_LEVEL_ADDR |=> rdData == $past(inLines))
    else $error("Input level read wrong");
  chk_timer_read_map: assert property (
    cpuReq.rd && cpuReq.addr == CLK_TMR_ADDR |=> rdData[3:2] == 2'b00
      && rdData[1:0] == $past(periphStatus.clkTmr[1:0]))
    else $error("Timer read wrong");
  chk_hund_read_map: assert property (
    cpuReq.rd && cpuReq.addr == SW_HUND_ADDR |=> rdData == $past(periphStatus.swHund))
    else $error("Hundredths read wrong");
  chk_tenth_read_map: assert property (
    cpuReq.rd && cpuReq.addr == SW_TENTH_ADDR |=> rdData == $past(periphStatus.swTenth))
    else $error("Tenths read wrong");
  chk_ram_write_read: assert property (
    wrRam ##1 !cpuReq.wr
      ##1 (cpuReq.rd && !cpuReq.wr && cpuReq.addr == $past(cpuReq.addr, 2))
      |=> rdData == $past(cpuReq.wdata, 3))
    else $error("RAM readback wrong");
  chk_unmapped_zero: assert property (
    cpuReq.rd && decodeSel(cpuReq.addr) == SEL_NONE |=> rdData == ZERO_NIB)
    else $error("Unmapped read not zero");
  chk_ro_write_ignored: assert property (
    cpuReq.wr && cpuReq.addr == IN_LEVEL_ADDR ##2 cpuReq.rd && cpuReq.addr == IN_LEVEL_ADDR
      |=> rdData == $past(inLines))
    else $error("Read-only location took a write");
  chk_window_flag: assert property (
    (cpuReq.rd || cpuReq.wr) && cpuReq.addr <= RWIN_LAST |=> regWindowHit)
    else $error("Window flag missing");
  chk_start_addr: assert property (
    progPageCounter == START_PAGE && progStepCounter == START_STEP)
    else $error("Start address wrong");

  // ==========================================================
  // Checks on I/O register reads and writes, the display port and the bus handshake
  chk_lcd_upper_zero: assert property (
    cpuReq.rd && cpuReq.addr == LCD_BLANK_ADDR |=> rdData[3:1] == 3'h0)
    else $error("LCD control upper bits not zero");
  chk_cmp_read_back: assert property (
    cpuReq.rd && cpuReq.addr == IN_CMP_ADDR |=> rdData == $past(inCmp))
    else $error("Comparison register read wrong");
  chk_irq_read_back: assert property (
    cpuReq.rd && cpuReq.addr == IN_IRQ_ADDR |=> rdData == $past(inIrqEn))
    else $error("Interrupt enable read wrong");
  chk_disp0_strobe: assert property (
    cpuReq.wr && isDisp0(cpuReq.addr) |=> dispWrStrobe && dispWrData == $past(cpuReq.wdata))
    else $error("Page 0 display write not passed on");
  chk_disp0_ram_write: assert property (
    cpuReq.wr && isDisp0(cpuReq.addr) |-> wrRam)
    else $error("Page 0 display write missed RAM");
  chk_disp2_strobe: assert property (
    cpuReq.wr && sel == SEL_DISP |=> dispWrStrobe && dispWrData == $past(cpuReq.wdata))
    else $error("Page 2 display write not passed on");
  chk_disp2_no_read: assert property (
    cpuReq.rd && sel == SEL_DISP |=> rdData == ZERO_NIB)
    else $error("Page 2 display read not zero");
  chk_disp2_not_ram: assert property (
    cpuReq.wr && sel == SEL_DISP |-> !wrRam)
    else $error("Page 2 display write reached RAM");
  chk_disp_index_range: assert property (
    dispWrStrobe |-> dispWrIndex < 6'(DISP_WORDS))
    else $error("Display index out of range");
  chk_strobe_needs_write: assert property (
    dispWrStrobe |-> $past(cpuReq.wr))
    else $error("Display strobe without a write");
  chk_valid_follows_rd: assert property (
    cpuReq.rd |=> rdValid)
    else $error("Read not answered");
  chk_valid_idle: assert property (
    !cpuReq.rd |=> !rdValid)
    else $error("Read answer without a read");
  chk_window_flag_low: assert property (
    !(cpuReq.rd || cpuReq.wr) |=> !regWindowHit)
    else $error("Window flag without an access");
  chk_ro_regs_kept: assert property (
    wrIo && cpuReq.addr == CLK_TMR_ADDR
      |=> $stable(inCmp) && $stable(inIrqEn) && $stable(lcdBlankN))
    else $error("Write to timer word changed a register");
  chk_unmapped_write_safe: assert property (
    cpuReq.wr && sel == SEL_NONE
      |=> $stable(inCmp) && $stable(inIrqEn) && $stable(lcdBlankN))
    else $error("Unmapped write changed a register");

  cov_ram_write: cover property (wrRam);
  cov_disp_write: cover property (dispWrStrobe);
  cov_io_write: cover property (wrIo);
  cov_level_read: cover property (cpuReq.rd && cpuReq.addr == IN_LEVEL_ADDR);
  cov_disp2_read: cover property (cpuReq.rd && sel == SEL_DISP);
endmodule

// File: test/ndm_cpu_model.sv
// CPU core model: one nibble access per read or write call, three per call entry, on the internal data bus
`timescale 1ns/1ps
module ndm_cpu_model
(
  input  wire logic         clock,
  output ndm_pkg::ndm_req_t cpuReq,
  input  wire logic [3:0]   rdData,
  input  wire logic         rdValid
);
  import ndm_pkg::*;

  initial cpuReq = '0;

  // ==========================================================
  // Bus cycles
  // Idle bus shows inverted values so a stale address never looks valid
  task automatic cpuWrite(input logic [9:0] a, input logic [3:0] d);
    @(posedge clock);
    cpuReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    cpuReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    // Let the edge settle so callers see the registered result
    #1;
  endtask

  task automatic cpuRead(input logic [9:0] a, output logic [3:0] d, output logic v);
    @(posedge clock);
    cpuReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0};
    @(posedge clock);
    cpuReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 4'hF};
    #1;
    d = rdData;
    v = rdValid;
  endtask

  // ==========================================================
  // Call entry
  // three stack words
  task automatic pushReturn(input logic [9:0] sp, input logic [11:0] pc);
    for (int i = 0; i < STACK_PUSH; i++)
      cpuWrite(sp - 10'(i + 1), pc[4*i +: 4]);
  endtask
endmodule

// File: test/nibble_data_memory_io_map_bench.sv
// Testbench of the nibble data memory map, page 0 and page 2 display builds side by side
`timescale 1ns/1ps
module nibble_data_memory_io_map_bench;
  import ndm_pkg::*;
  logic        clock, rst_b;
  ndm_req_t    cpuReq;
  ndm_status_t periphStatus;
  logic [3:0]  inLines, rdDataA, rdDataB, inCmpA, inIrqEnA, dispWrDataB;
  logic        rdValidA, rdValidB, winHitA, lcdBlankNA, strobeA, strobeB;
  logic [5:0]  dispWrIndexB;
  logic [7:0]  progStepCounterA;
  logic [3:0]  progPageCounterA;
  int          num_errors, checks_done, cycles, strA, strB;

  ndm_data_map #(.DISP_PAGE2(1'b0)) ndm_data_map_i (.clock(clock), .rst_b(rst_b),
    .cpuReq(cpuReq), .periphStatus(periphStatus), .inLines(inLines), .rdData(rdDataA),
    .rdValid(rdValidA), .regWindowHit(winHitA), .lcdBlankN(lcdBlankNA), .inCmp(inCmpA),
    .inIrqEn(inIrqEnA), .dispWrStrobe(strobeA), .dispWrIndex(), .dispWrData(),
    .progStepCounter(progStepCounterA), .progPageCounter(progPageCounterA));
  // Second build shares the bus so one access exercises both placements
  ndm_data_map #(.DISP_PAGE2(1'b1)) ndm_data_map_p2_i (.clock(clock), .rst_b(rst_b),
    .cpuReq(cpuReq), .periphStatus(periphStatus), .inLines(inLines), .rdData(rdDataB),
    .rdValid(rdValidB), .regWindowHit(), .lcdBlankN(), .inCmp(), .inIrqEn(),
    .dispWrStrobe(strobeB), .dispWrIndex(dispWrIndexB), .dispWrData(dispWrDataB),
    .progStepCounter(), .progPageCounter());
  ndm_cpu_model ndm_cpu_model_i (.clock(clock), .cpuReq(cpuReq), .rdData(rdDataA),
    .rdValid(rdValidA));

  // ==========================================================
  // Clock, strobe counting and hang guard
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock)
  begin
    if (strobeA === 1'b1) strA++;
    if (strobeB === 1'b1) strB++;
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      results();
    end
  end

  // ==========================================================
  // Checking
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdChk(input logic [9:0] a, input logic [3:0] eA, input logic [3:0] eB);
    logic [3:0] d;
    logic       v;
    ndm_cpu_model_i.cpuRead(a, d, v);
    check(d, eA);
    check(v, 1'b1);
    check(rdValidB, 1'b1);
    check(rdDataB, eB);
  endtask

  task automatic results();
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    logic [9:0] ram [6];
    ram = '{10'h000, 10'h00F, 10'h010, 10'h06F, 10'h1AB, 10'h33F};
    rst_b = 1'b0;
    periphStatus = '{clkTmr: 4'hB, swHund: 4'h7, swTenth: 4'h9};
    inLines = 4'hA;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    check(lcdBlankNA, 1'b1);
    check(inCmpA, 4'h0);
    check(inIrqEnA, 4'h0);
    check(progStepCounterA, 8'h00);
    check(progPageCounterA, 4'h1);
    rdChk(LCD_BLANK_ADDR, 4'h1, 4'h1);
    rdChk(IN_CMP_ADDR, 4'h0, 4'h0);
    rdChk(IN_IRQ_ADDR, 4'h0, 4'h0);
    rdChk(CLK_TMR_ADDR, 4'h3, 4'h3);
    rdChk(SW_HUND_ADDR, 4'h7, 4'h7);
    rdChk(SW_TENTH_ADDR, 4'h9, 4'h9);
    rdChk(IN_LEVEL_ADDR, 4'hA, 4'hA);
    @(posedge clock) inLines <= 4'h5;
    rdChk(IN_LEVEL_ADDR, 4'h5, 4'h5);
    // Writes to status words must not disturb them
    for (int a = 0; a < 4; a++) ndm_cpu_model_i.cpuWrite(CLK_TMR_ADDR + 10'(a), 4'h0);
    rdChk(IN_LEVEL_ADDR, 4'h5, 4'h5);
    rdChk(CLK_TMR_ADDR, 4'h3, 4'h3);
    rdChk(SW_HUND_ADDR, 4'h7, 4'h7);
    rdChk(SW_TENTH_ADDR, 4'h9, 4'h9);
    ndm_cpu_model_i.cpuWrite(LCD_BLANK_ADDR, 4'hE);
    check(lcdBlankNA, 1'b0);
    rdChk(LCD_BLANK_ADDR, 4'h0, 4'h0);
    ndm_cpu_model_i.cpuWrite(LCD_BLANK_ADDR, 4'hF);
    rdChk(LCD_BLANK_ADDR, 4'h1, 4'h1);
    ndm_cpu_model_i.cpuWrite(IN_CMP_ADDR, 4'h5);
    check(inCmpA, 4'h5);
    rdChk(IN_CMP_ADDR, 4'h5, 4'h5);
    ndm_cpu_model_i.cpuWrite(IN_IRQ_ADDR, 4'hA);
    check(inIrqEnA, 4'hA);
    rdChk(IN_IRQ_ADDR, 4'hA, 4'hA);
    for (int i = 0; i < 6; i++) ndm_cpu_model_i.cpuWrite(ram[i], 4'(i + 3));
    for (int i = 0; i < 6; i++)
    begin
      rdChk(ram[i], 4'(i + 3), 4'(i + 3));
      check(winHitA, ram[i] <= RWIN_LAST);
    end
    check(strA, 1);
    check(strB, 0);
    ndm_cpu_model_i.cpuWrite(DISP2_LAST, 4'h6);
    check(strobeB, 1'b1);
    check(strobeA, 1'b0);
    check(dispWrIndexB, 6'h2F);
    check(dispWrDataB, 4'h6);
    rdChk(DISP2_LAST, 4'h6, 4'h0);
    check(strB, 1);
    ndm_cpu_model_i.cpuWrite(10'h340, 4'hC);
    rdChk(10'h340, 4'h0, 4'h0);
    rdChk(10'h2D1, 4'h0, 4'h0);
    rdChk(10'h3FF, 4'h0, 4'h0);
    ndm_cpu_model_i.pushReturn(10'h0FF, 12'h1A5);
    rdChk(10'h0FE, 4'h5, 4'h5);
    rdChk(10'h0FD, 4'hA, 4'hA);
    rdChk(10'h0FC, 4'h1, 4'h1);
    ndm_cpu_model_i.cpuWrite(LCD_BLANK_ADDR, 4'h0);
    check(lcdBlankNA, 1'b0);
    // Second reset in mid-run
    @(posedge clock) rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    check(inCmpA, 4'h0);
    check(lcdBlankNA, 1'b1);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    rdChk(IN_IRQ_ADDR, 4'h0, 4'h0);
    results();
  end
endmodule
